// ---- bench/uepd_endpoint_desc_bench.sv ----
// Self-checking bench for the endpoint descriptor block.
`timescale 1ns/100ps
module uepd_endpoint_desc_bench
    import uepd_pkg::*;
;
    logic        ref_clk, reset_n, ce, mcu_wr, mcu_rd, mcu_wait;
    logic [6:0]  mcu_addr, xfer_len, xfer_rx_len;
    logic [7:0]  mcu_wdata, mcu_rdata;
    logic        tok_valid, tok_in, hs_valid, xfer_end, xfer_abort;
    logic [2:0]  tok_ep, irq_ep;
    logic [1:0]  hs_code;
    logic [10:0] xfer_addr;
    logic        xfer_irq;
    int          miscompares;
    int          checks_done;
    // Rows: address, written byte, byte read back.
    localparam logic [22:0] ROWS [7] = '{
        {7'h48, 8'h87, 8'h84}, {7'h0F, 8'hC0, 8'h40}, {7'h0D, 8'h12, 8'h12},
        {7'h0E, 8'h85, 8'h85}, {7'h0A, 8'h03, 8'h03}, {7'h0B, 8'h55, 8'h00},
        {7'h03, 8'h77, 8'h00}};

    uepd_endpoint_desc uepd_endpoint_desc_i (.ref_clk(ref_clk),
        .reset_n(reset_n), .ce(ce), .mcu_addr(mcu_addr), .mcu_wr(mcu_wr),
        .mcu_rd(mcu_rd), .mcu_wdata(mcu_wdata), .mcu_rdata(mcu_rdata),
        .mcu_wait(mcu_wait), .tok_valid(tok_valid), .tok_in(tok_in),
        .tok_ep(tok_ep), .hs_valid(hs_valid), .hs_code(hs_code),
        .xfer_addr(xfer_addr), .xfer_len(xfer_len), .xfer_end(xfer_end),
        .xfer_abort(xfer_abort), .xfer_rx_len(xfer_rx_len),
        .xfer_irq(xfer_irq), .irq_ep(irq_ep));
    uepd_host_model uepd_host_model_i (.ref_clk(ref_clk),
        .hs_valid(hs_valid), .hs_code(hs_code), .tok_valid(tok_valid),
        .tok_in(tok_in), .tok_ep(tok_ep), .xfer_end(xfer_end),
        .xfer_abort(xfer_abort), .xfer_rx_len(xfer_rx_len));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        mcu_addr  = a;
        mcu_wdata = d;
        mcu_wr    = 1'b1;
        @(posedge ref_clk);
        #1;
        mcu_wr    = 1'b0;
        mcu_wdata = ~d;
    endtask : wr

    task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        #1;
        mcu_addr = a;
        mcu_rd   = 1'b1;
        @(posedge ref_clk);
        #1;
        mcu_rd = 1'b0;
        chk({8'h00, mcu_rdata}, {8'h00, exp});
    endtask : rdchk

    task automatic tok(input logic in, input logic [2:0] ep,
                       input logic es, input logic [1:0] ec);
        logic       seen;
        logic [1:0] code;
        uepd_host_model_i.send_token(in, ep, seen, code);
        chk({13'h0000, seen, code}, {13'h0000, es, es ? ec : 2'h3});
    endtask : tok

    task automatic done(input logic [6:0] len, input logic ab, input int slow,
                        input logic ei);
        logic       seen;
        logic [2:0] ep;
        seen = 1'b0;
        ep   = 3'h0;
        uepd_host_model_i.finish(len, ab, slow);
        repeat (6) begin
            @(posedge ref_clk);
            #1;
            if (xfer_irq === 1'b1) begin
                seen = 1'b1;
                ep   = irq_ep;
            end
        end
        chk({12'h000, seen, ep}, {12'h000, ei, ei ? 3'h2 : 3'h0});
    endtask : done

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        stop_test();
    end

    initial begin
        {reset_n, ce, mcu_wr, mcu_rd} = 4'h4;
        mcu_addr    = 7'h00;
        mcu_wdata   = 8'h00;
        miscompares = 0;
        checks_done = 0;
        repeat (12) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        chk({1'b0, hs_valid, hs_code, xfer_irq, irq_ep, mcu_rdata}, 16'h0000);
        chk({5'h00, xfer_addr}, 16'h0000);
        rdchk(7'h48, 8'h00);
        foreach (ROWS[i]) begin
            wr(ROWS[i][22:16], ROWS[i][15:8]);
            rdchk(ROWS[i][22:16], ROWS[i][7:0]);
        end
        // firmware leaves the isochronous bit clear throughout.
        wr(7'h11, 8'h21);
        wr(7'h12, 8'h00);
        wr(7'h15, 8'h33);
        wr(7'h16, 8'h00);
        wr(7'h17, 8'h30);
        wr(7'h10, 8'h84);
        tok(1'b0, 3'h2, 1'b1, HS_ACK);
        chk({xfer_len, 9'h000}, {7'h30, 9'h000});
        chk({5'h00, xfer_addr}, 16'h0108);
        done(7'h0A, 1'b0, 3, 1'b1);
        rdchk(7'h12, 8'h8A);
        rdchk(7'h10, 8'hA4);
        rdchk(7'h11, 8'h21);
        tok(1'b0, 3'h2, 1'b1, HS_NAK);
        wr(7'h10, 8'hB4);
        tok(1'b0, 3'h2, 1'b1, HS_ACK);
        chk({5'h00, xfer_addr}, 16'h0198);
        done(7'h40, 1'b0, 0, 1'b1);
        rdchk(7'h16, 8'hC0);
        rdchk(7'h10, 8'h94);
        rdchk(7'h15, 8'h33);
        tok(1'b0, 3'h2, 1'b1, HS_NAK);
        wr(7'h12, 8'h00);
        wr(7'h10, 8'h90);
        tok(1'b0, 3'h2, 1'b1, HS_ACK);
        done(7'h05, 1'b1, 0, 1'b0);
        rdchk(7'h12, 8'h00);
        tok(1'b0, 3'h2, 1'b1, HS_ACK);
        done(7'h05, 1'b0, 0, 1'b0);
        rdchk(7'h10, 8'hB0);
        wr(7'h10, 8'h08);
        tok(1'b0, 3'h2, 1'b1, HS_STALL);
        wr(7'h10, 8'h00);
        tok(1'b0, 3'h2, 1'b1, HS_NAK);
        wr(7'h48, 8'h88);
        tok(1'b1, 3'h1, 1'b1, HS_STALL);
        tok(1'b0, 3'h0, 1'b0, HS_ACK);
        // IN transfer on endpoint two: count keeps its length, flag set.
        wr(7'h51, 8'h10);
        wr(7'h52, 8'h05);
        wr(7'h50, 8'h84);
        tok(1'b1, 3'h2, 1'b1, HS_ACK);
        chk({xfer_len, 9'h000}, {7'h05, 9'h000});
        chk({5'h00, xfer_addr}, 16'h0080);
        done(7'h00, 1'b0, 0, 1'b1);
        rdchk(7'h52, 8'h85);
        rdchk(7'h50, 8'hA4);
        // A firmware write that meets the engine's count update is refused.
        wr(7'h10, 8'h80);
        wr(7'h12, 8'h00);
        tok(1'b0, 3'h2, 1'b1, HS_ACK);
        uepd_host_model_i.finish(7'h07, 1'b0, 0);
        mcu_addr  = 7'h12;
        mcu_wdata = 8'h00;
        mcu_wr    = 1'b1;
        @(posedge ref_clk);
        #1;
        chk({15'h0000, mcu_wait}, 16'h0001);
        mcu_wr = 1'b0;
        rdchk(7'h12, 8'h87);
        // With the clock enable low a token must go unanswered.
        ce = 1'b0;
        tok(1'b0, 3'h2, 1'b0, HS_ACK);
        ce = 1'b1;
        // Reset in the middle of a data stage.
        wr(7'h12, 8'h00);
        tok(1'b0, 3'h2, 1'b1, HS_ACK);
        reset_n = 1'b0;
        @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        chk({1'b0, hs_valid, hs_code, xfer_irq, irq_ep, mcu_rdata}, 16'h0000);
        chk({1'b0, xfer_len, xfer_addr[10:3]}, 16'h0000);
        rdchk(7'h10, 8'h00);
        tok(1'b0, 3'h2, 1'b1, HS_NAK);
        stop_test();
    end
endmodule : uepd_endpoint_desc_bench

// ---- bench/uepd_host_model.sv ----
// Behavioural USB host and data path facing the endpoint engine.
`timescale 1ns/100ps
module uepd_host_model (
    input  wire logic       ref_clk,
    input  wire logic       hs_valid,
    input  wire logic [1:0] hs_code,
    output logic            tok_valid,
    output logic            tok_in,
    output logic [2:0]      tok_ep,
    output logic            xfer_end,
    output logic            xfer_abort,
    output logic [6:0]      xfer_rx_len
);
    initial begin
        tok_valid   = 1'b0;
        tok_in      = 1'b0;
        tok_ep      = 3'h0;
        xfer_end    = 1'b0;
        xfer_abort  = 1'b0;
        xfer_rx_len = 7'h00;
    end

    ////////////////////////////////////////////////////////////////////
    // Lines are inverted after each pulse, so a late sampler sees junk.
    task automatic send_token(input logic in, input logic [2:0] ep,
                              output logic seen, output logic [1:0] code);
        @(posedge ref_clk);
        #1;
        tok_valid = 1'b1;
        tok_in    = in;
        tok_ep    = ep;
        @(posedge ref_clk);
        #1;
        tok_valid = 1'b0;
        tok_in    = ~in;
        tok_ep    = ~ep;
        seen      = 1'b0;
        code      = 2'h3;
        for (int k = 0; k < 3 && !seen; k++) begin
            if (hs_valid === 1'b1) begin
                seen = 1'b1;
                code = hs_code;
            end else begin
                @(posedge ref_clk);
                #1;
            end
        end
    endtask : send_token

    // received lengths stay within sixty-four bytes.
    task automatic finish(input logic [6:0] len, input logic abort,
                          input int slow);
        repeat (slow) @(posedge ref_clk);
        @(posedge ref_clk);
        #1;
        xfer_end    = ~abort;
        xfer_abort  = abort;
        xfer_rx_len = (len > 7'h40) ? 7'h40 : len;
        @(posedge ref_clk);
        #1;
        xfer_end    = 1'b0;
        xfer_abort  = 1'b0;
        xfer_rx_len = ~len;
    endtask : finish
endmodule : uepd_host_model

// ---- inc/uepd_desc_if.sv ----
// Descriptor fields of one endpoint and the buffer chosen from them.
`timescale 1ns/100ps
interface uepd_desc_if;
    logic [7:0]  cfg;
    logic [7:0]  xbase;
    logic [7:0]  xcnt;
    logic [7:0]  ybase;
    logic [7:0]  ycnt;
    logic        sel_y;
    logic [10:0] base;
    logic [7:0]  cnt;
    modport src (output cfg, xbase, xcnt, ybase, ycnt,
                 input sel_y, base, cnt);
    modport sel (input cfg, xbase, xcnt, ybase, ycnt,
                 output sel_y, base, cnt);
endinterface : uepd_desc_if

// ---- inc/uepd_pkg.sv ----
// Shared constants and types for the USB endpoint descriptor block.
package uepd_pkg;
    localparam logic [2:0] OFF_CFG   = 3'h0;
    localparam logic [2:0] OFF_XBASE = 3'h1;
    localparam logic [2:0] OFF_XCNT  = 3'h2;
    localparam logic [2:0] OFF_SPR0  = 3'h3;
    localparam logic [2:0] OFF_SPR1  = 3'h4;
    localparam logic [2:0] OFF_YBASE = 3'h5;
    localparam logic [2:0] OFF_YCNT  = 3'h6;
    localparam logic [2:0] OFF_SIZE  = 3'h7;
    localparam int BIT_IE    = 2;
    localparam int BIT_STALL = 3;
    localparam int BIT_DBL   = 4;
    localparam int BIT_TOG   = 5;
    localparam int BIT_BMEN  = 7;
    localparam int BIT_OWN   = 7;
    localparam logic [6:0] CNT_MAX    = 7'h40;
    localparam logic [7:0] CFG_RST    = 8'h00;
    localparam logic [7:0] CFG_RMASK  = 8'hFC;
    localparam logic [7:0] SIZE_RMASK = 8'h7F;
    localparam logic [1:0] HS_ACK   = 2'h0;
    localparam logic [1:0] HS_NAK   = 2'h1;
    localparam logic [1:0] HS_STALL = 2'h2;

    typedef enum {ST_IDLE, ST_DATA, ST_CNT, ST_CFG} uepd_state_t;

    function automatic logic [10:0] uepd_addr(input logic [7:0] base);
        return {base, 3'h0};
    endfunction : uepd_addr

    function automatic logic [6:0] uepd_clamp(input logic [6:0] n);
        return (n > CNT_MAX) ? CNT_MAX : n;
    endfunction : uepd_clamp
endpackage : uepd_pkg

// ---- src/uepd_bufsel.sv ----
// Picks the X or Y buffer of an endpoint and forms its start address.
`timescale 1ns/100ps
module uepd_bufsel
    import uepd_pkg::*;
(
    uepd_desc_if.sel d
);
    always_comb begin
        d.sel_y = d.cfg[BIT_DBL] & d.cfg[BIT_TOG];
        d.base  = d.sel_y ? uepd_addr(d.ybase) : uepd_addr(d.xbase);
        d.cnt   = d.sel_y ? d.ycnt : d.xcnt;
    end
endmodule : uepd_bufsel

// ---- src/uepd_endpoint_desc.sv ----
// Endpoint descriptor store and transaction engine for endpoints 1 to 7.
`timescale 1ns/100ps
//
// Contract
// - owned OUT buffer answers host with NAK.
// - free OUT buffer accepts next host packet.
// - byte counts never exceed sixty-four.
// - shared buffer size, bit seven reads zero.
// - Y base gives address bits ten to three.
// - engine starts at base, never rewrites it.
// - completion interrupt only when enabled.
// - stall bit answers STALL, resets clear.
// - single buffering uses X buffer only.
// - toggle bit tracks DATA0/DATA1 sequence.
// - engine serves endpoint only when enabled.
// - eight-byte descriptor with fixed offsets.
// - X base padded likewise, starts X transfers.
module uepd_endpoint_desc
    import uepd_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       ce,
    input  wire logic [6:0] mcu_addr,
    input  wire logic       mcu_wr,
    input  wire logic       mcu_rd,
    input  wire logic [7:0] mcu_wdata,
    output logic [7:0]      mcu_rdata,
    output logic            mcu_wait,
    input  wire logic       tok_valid,
    input  wire logic       tok_in,
    input  wire logic [2:0] tok_ep,
    output logic            hs_valid,
    output logic [1:0]      hs_code,
    output logic [10:0]     xfer_addr,
    output logic [6:0]      xfer_len,
    input  wire logic       xfer_end,
    input  wire logic       xfer_abort,
    input  wire logic [6:0] xfer_rx_len,
    output logic            xfer_irq,
    output logic [2:0]      irq_ep
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  mem [128];
    uepd_state_t state_r;
    uepd_state_t state_nxt;
    logic        dir_r;
    logic        dir_nxt;
    logic [2:0]  ep_r;
    logic [2:0]  ep_nxt;
    logic        sel_y_r;
    logic        sel_y_nxt;
    logic [6:0]  len_r;
    logic [6:0]  len_nxt;
    logic        hs_valid_r;
    logic        hs_valid_nxt;
    logic [1:0]  hs_code_r;
    logic [1:0]  hs_code_nxt;
    logic [10:0] addr_r;
    logic [10:0] addr_nxt;
    logic        irq_r;
    logic        irq_nxt;
    logic [2:0]  irq_ep_r;
    logic [2:0]  irq_ep_nxt;
    logic        fsm_we;
    logic [6:0]  fsm_waddr;
    logic [7:0]  fsm_wdata;
    logic        mcu_we;
    logic [7:0]  mcu_wbyte;
    logic        cur_dir;
    logic [2:0]  cur_ep;
    logic        tok_take;
    logic        ie_bit;

    uepd_desc_if d ();

    // byte index is direction, endpoint, offset.
    function automatic logic [6:0] idx(input logic dir,
                                       input logic [2:0] ep,
                                       input logic [2:0] off);
        return {dir, ep, off};
    endfunction : idx

    ////////////////////////////////////////////////////////////////////////
    uepd_bufsel u_sel (
        .d (d)
    );

    uepd_mcu_port u_mcu (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .ce        (ce),
        .mcu_addr  (mcu_addr),
        .mcu_wr    (mcu_wr),
        .mcu_rd    (mcu_rd),
        .mcu_wdata (mcu_wdata),
        .rd_byte   (mem[mcu_addr]),
        .fsm_we    (fsm_we),
        .mem_we    (mcu_we),
        .mem_wdata (mcu_wbyte),
        .mcu_rdata (mcu_rdata),
        .mcu_wait  (mcu_wait)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        cur_dir  = (state_r == ST_IDLE) ? tok_in : dir_r;
        cur_ep   = (state_r == ST_IDLE) ? tok_ep : ep_r;
        d.cfg    = mem[idx(cur_dir, cur_ep, OFF_CFG)];
        d.xbase  = mem[idx(cur_dir, cur_ep, OFF_XBASE)];
        d.xcnt   = mem[idx(cur_dir, cur_ep, OFF_XCNT)];
        d.ybase  = mem[idx(cur_dir, cur_ep, OFF_YBASE)];
        d.ycnt   = mem[idx(cur_dir, cur_ep, OFF_YCNT)];
        ie_bit   = d.cfg[BIT_IE];
        // Endpoint zero lives elsewhere, so its tokens are left alone.
        tok_take = ce && (state_r == ST_IDLE) && tok_valid
                   && (tok_ep != 3'h0);
    end

    always_comb begin
        state_nxt    = state_r;
        dir_nxt      = dir_r;
        ep_nxt       = ep_r;
        sel_y_nxt    = sel_y_r;
        len_nxt      = len_r;
        addr_nxt     = addr_r;
        hs_valid_nxt = 1'b0;
        hs_code_nxt  = hs_code_r;
        irq_nxt      = 1'b0;
        irq_ep_nxt   = irq_ep_r;
        fsm_we       = 1'b0;
        fsm_waddr    = 7'h00;
        fsm_wdata    = 8'h00;
        case (state_r)
            ST_IDLE: begin
                if (tok_take) begin
                    dir_nxt      = tok_in;
                    ep_nxt       = tok_ep;
                    sel_y_nxt    = d.sel_y;
                    hs_valid_nxt = 1'b1;
                    if (d.cfg[BIT_STALL]) begin
                        hs_code_nxt = HS_STALL;
                    end else if (!d.cfg[BIT_BMEN] || d.cnt[BIT_OWN]) begin
                        hs_code_nxt = HS_NAK;
                    end else begin
                        hs_code_nxt = HS_ACK;
                        addr_nxt    = d.base;
                        len_nxt     = tok_in ? uepd_clamp(d.cnt[6:0])
                                      : uepd_clamp(
                                        mem[idx(tok_in, tok_ep,
                                                OFF_SIZE)][6:0]);
                        state_nxt   = ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                if (xfer_abort) begin
                    state_nxt = ST_IDLE;
                end else if (xfer_end) begin
                    if (!dir_r) begin
                        len_nxt = uepd_clamp(xfer_rx_len);
                    end
                    state_nxt = ST_CNT;
                end
            end
            ST_CNT: begin
                // store length, hand buffer to firmware.
                fsm_we    = 1'b1;
                fsm_waddr = idx(dir_r, ep_r,
                                sel_y_r ? OFF_YCNT : OFF_XCNT);
                fsm_wdata = {1'b1, len_r};
                state_nxt = ST_CFG;
            end
            ST_CFG: begin
                fsm_we    = 1'b1;
                fsm_waddr = idx(dir_r, ep_r, OFF_CFG);
                fsm_wdata = d.cfg ^ (8'h01 << BIT_TOG);
                irq_nxt    = d.cfg[BIT_IE];
                irq_ep_nxt = ep_r;
                state_nxt  = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_r    <= ST_IDLE;
            dir_r      <= 1'b0;
            ep_r       <= 3'h0;
            sel_y_r    <= 1'b0;
            len_r      <= 7'h00;
            hs_valid_r <= 1'b0;
            hs_code_r  <= HS_ACK;
            addr_r     <= 11'h000;
            irq_r      <= 1'b0;
            irq_ep_r   <= 3'h0;
        end else if (ce) begin
            state_r    <= state_nxt;
            dir_r      <= dir_nxt;
            ep_r       <= ep_nxt;
            sel_y_r    <= sel_y_nxt;
            len_r      <= len_nxt;
            hs_valid_r <= hs_valid_nxt;
            hs_code_r  <= hs_code_nxt;
            addr_r     <= addr_nxt;
            irq_r      <= irq_nxt;
            irq_ep_r   <= irq_ep_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Only configuration bytes are cleared; the rest stay undefined until
    // firmware writes them, which keeps the store free of reset muxes.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            // stall and all control bits reset clear.
            for (int i = 0; i < 16; i++) begin
                mem[i * 8] <= CFG_RST;
            end
        end else if (ce) begin
            if (fsm_we) begin
                mem[fsm_waddr] <= fsm_wdata;
            end else if (mcu_we) begin
                mem[mcu_addr] <= mcu_wbyte;
            end
        end
    end

    assign hs_valid  = hs_valid_r;
    assign hs_code   = hs_code_r;
    assign xfer_addr = addr_r;
    assign xfer_len  = len_r;
    assign xfer_irq  = irq_r;
    assign irq_ep    = irq_ep_r;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_out_done;
        ce && state_r == ST_DATA && xfer_end && !xfer_abort && !dir_r;
    endsequence

    sequence s_upd;
        ce && state_r == ST_CFG;
    endsequence

    a_nak_owned: assert property (
        tok_take && !tok_in && !d.cfg[BIT_STALL] && d.cnt[BIT_OWN]
        |=> hs_valid && hs_code == HS_NAK)
        else $error("owned OUT buffer not NAKed");
    a_ack_free: assert property (
        tok_take && !tok_in && !d.cfg[BIT_STALL] && d.cfg[BIT_BMEN]
        && !d.cnt[BIT_OWN] |=> hs_valid && hs_code == HS_ACK
        && state_r == ST_DATA)
        else $error("free OUT buffer not accepted");
    a_count_max: assert property (
        fsm_we && state_r == ST_CNT |-> fsm_wdata[6:0] <= CNT_MAX)
        else $error("count above sixty-four written");
    a_y_address: assert property (
        tok_take && d.sel_y && hs_code_nxt == HS_ACK
        |=> xfer_addr == {$past(d.ybase), 3'h0})
        else $error("Y start address wrong");
    a_base_kept: assert property (
        fsm_we |-> fsm_waddr[2:0] != OFF_XBASE
        && fsm_waddr[2:0] != OFF_YBASE)
        else $error("engine wrote a base entry");
    a_irq_gate: assert property (
        s_upd |=> xfer_irq == $past(ie_bit) ##1 !xfer_irq || !ce)
        else $error("interrupt not gated by enable");
    a_stall_reply: assert property (
        tok_take && d.cfg[BIT_STALL] |=> hs_valid && hs_code == HS_STALL)
        else $error("stall not answered");
    a_x_only: assert property (
        tok_take && !d.cfg[BIT_DBL] |=> !sel_y_r)
        else $error("Y buffer used without double buffering");
    a_toggle_flip: assert property (
        s_upd |-> fsm_we && fsm_wdata[BIT_TOG] != d.cfg[BIT_TOG])
        else $error("toggle not flipped");
    a_enable_gate: assert property (
        tok_take && !d.cfg[BIT_BMEN] |=> hs_code != HS_ACK)
        else $error("disabled endpoint served");
    a_owner_set: assert property (
        s_out_done ##1 ce |-> fsm_we && fsm_wdata[BIT_OWN]
        && fsm_wdata[6:0] == uepd_clamp($past(xfer_rx_len)))
        else $error("OUT count or ownership not stored");
    a_y_data1: assert property (
        tok_take && d.cfg[BIT_DBL] && d.cfg[BIT_TOG] |=> sel_y_r)
        else $error("DATA1 did not pick Y buffer");
    a_x_address: assert property (
        tok_take && !d.sel_y && hs_code_nxt == HS_ACK
        |=> xfer_addr == {$past(d.xbase), 3'h0})
        else $error("X start address wrong");
    a_len_max: assert property (
        hs_valid && hs_code == HS_ACK |-> xfer_len <= CNT_MAX)
        else $error("transfer length above sixty-four");
    a_ep0_ignored: assert property (
        ce && tok_valid && tok_ep == 3'h0 |=> !hs_valid)
        else $error("endpoint zero token answered");
    a_busy_ignored: assert property (
        ce && tok_valid && state_r != ST_IDLE |=> !hs_valid)
        else $error("token answered while busy");
    a_abort_idle: assert property (
        ce && state_r == ST_DATA && xfer_abort |=> state_r == ST_IDLE)
        else $error("abort did not return to idle");
endmodule : uepd_endpoint_desc

// ---- src/uepd_mcu_port.sv ----
// Microcontroller access to the descriptor bytes.
`timescale 1ns/100ps
module uepd_mcu_port
    import uepd_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       ce,
    input  wire logic [6:0] mcu_addr,
    input  wire logic       mcu_wr,
    input  wire logic       mcu_rd,
    input  wire logic [7:0] mcu_wdata,
    input  wire logic [7:0] rd_byte,
    input  wire logic       fsm_we,
    output logic            mem_we,
    output logic [7:0]      mem_wdata,
    output logic [7:0]      mcu_rdata,
    output logic            mcu_wait
);
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       mapped;

    // reserved bits stored and read as zero.
    function automatic logic [7:0] mask(input logic [2:0] off,
                                        input logic [7:0] v);
        case (off)
            OFF_CFG:  return v & CFG_RMASK;
            OFF_SIZE: return v & SIZE_RMASK;
            default:  return v;
        endcase
    endfunction : mask

    always_comb begin
        // endpoint zero and spare bytes unmapped.
        mapped = (mcu_addr[5:3] != 3'h0) && (mcu_addr[2:0] != OFF_SPR0)
                 && (mcu_addr[2:0] != OFF_SPR1);
        // The engine owns the write port during its update steps.
        mcu_wait  = mcu_wr & mapped & fsm_we;
        mem_we    = ce & mcu_wr & mapped & ~fsm_we;
        mem_wdata = mask(mcu_addr[2:0], mcu_wdata);
        rdata_nxt = rdata_r;
        if (mcu_rd) begin
            rdata_nxt = mapped ? mask(mcu_addr[2:0], rd_byte) : 8'h00;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rdata_r <= 8'h00;
        end else if (ce) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign mcu_rdata = rdata_r;
endmodule : uepd_mcu_port
